/* rtl/adcdmx_top.v */
// Output clocking, sample routing and demux of the dual byte converter.
// Function
// - DES samples one input on both clock edges.
// - 1:4 order is q_del, i_del, q_prim, i_prim.
// - Non-demux DES: i_prim earlier, q_prim later; Q select swaps.
// - Pin mode samples I; register picks I/Q.
// - DES continuously trims I/Q clock phase.
// - 1:2 non-DES: primary 13, delayed 14 cycles.
// - 1:4 DES: I 13/14 fall, Q 13.5/14.5 rise.
// - Non-demux disables both delayed buses.
// - Non-demux latencies 13, 13.5 or 14 cycles.
// - 1:4 mode: four buses, one byte each.
// - Pin SDR edge select picks data edge.
// - Register SDR: edge bit selects data edge.
// - Register DDR: edge bit selects demux.
// - DDR clock has zero phase to data.
// - 1:2 non-DES demux DDR needs four sync cycles.
// - SDR clock equals bus data rate.
// - DDR clock half rate, both edges.
// - Floating edge pin selects DDR.
// - Duty cycle correction enabled after reset.
// - Forward differential data clock with buses.
// - Bytes are offset binary, clamped codes.
`timescale 1ns/1ps
`include "adcdmx_defines.vh"
module adcdmx_top #(
  parameter DEPTH = 15
) (
  input  wire        i_clk_sys,
  input  wire        i_rst_b,
  input  wire        i_sample_clk,
  input  wire [7:0]  i_conv_i_data,
  input  wire [7:0]  i_conv_q_data,
  input  wire        i_output_clock_reset,
  input  wire        i_ext_ctrl_b,
  input  wire        i_oes_level,
  input  wire        i_oes_float,
  input  wire        i_des_pin,
  input  wire        i_demux_pin,
  input  wire        i_hsel,
  input  wire [7:0]  i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg  [31:0] o_hrdata,
  output reg         o_hreadyout,
  output reg         o_hresp,
  output reg  [7:0]  o_i_bus_primary,
  output reg  [7:0]  o_i_bus_delayed,
  output reg  [7:0]  o_q_bus_primary,
  output reg  [7:0]  o_q_bus_delayed,
  output reg         o_delayed_oe,
  output reg         o_output_data_clock_p,
  output reg         o_output_data_clock_n,
  output reg         o_dcc_en,
  output reg  [5:0]  o_q_phase_trim
);

  localparam HW = DEPTH * 8;

  function [7:0] pick;
    input [HW-1:0] hist;
    input [3:0]    idx;
    begin
      pick = hist[idx*8 +: 8];
    end
  endfunction

  // Shifts a new byte into a history; index 0 is the newest entry.
  function [HW-1:0] push;
    input [HW-1:0] hist;
    input [7:0]    din;
    begin
      push = {hist[HW-9:0], din};
    end
  endfunction

  // Two-flop synchronisers; only the second stage feeds logic.
  // The sample clock, its data and the mode pins all come from outside
  // the system clock domain, so every one of them passes two stages.
  // Data and clock share the same depth, which keeps a sample aligned
  // with the edge that is detected for it.
  reg        clk_s1_ff;
  reg        clk_s2_ff;
  reg        clk_s3_ff;
  reg        rst_s1_ff;
  reg        rst_s2_ff;
  reg [4:0]  pin_s1_ff;
  reg [4:0]  pin_s2_ff;
  reg [15:0] dat_s1_ff;
  reg [15:0] dat_s2_ff;

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
      clk_s3_ff <= 1'b0;
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= 1'b1;
      pin_s1_ff <= 5'h00;
      pin_s2_ff <= 5'h00;
      dat_s1_ff <= 16'h0000;
      dat_s2_ff <= 16'h0000;
    end else begin
      clk_s1_ff <= i_sample_clk;
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
      rst_s1_ff <= i_output_clock_reset;
      rst_s2_ff <= rst_s1_ff;
      pin_s1_ff <= {i_ext_ctrl_b, i_oes_level, i_oes_float,
                    i_des_pin, i_demux_pin};
      pin_s2_ff <= pin_s1_ff;
      dat_s1_ff <= {i_conv_q_data, i_conv_i_data};
      dat_s2_ff <= dat_s1_ff;
    end
  end

  // An edge is seen one stage after the second synchroniser, so the
  // detected edge lags the pin by two to three system clocks.
  wire ev_rise = clk_s2_ff & ~clk_s3_ff;
  wire ev_fall = ~clk_s2_ff & clk_s3_ff;
  wire [7:0] din_i = dat_s2_ff[7:0];
  wire [7:0] din_q = dat_s2_ff[15:8];

  // Configuration register; software writes steer the mode.
  reg  [5:0] cfg_ff;
  wire pin_mode = pin_s2_ff[4];
  wire c_des    = pin_mode ? pin_s2_ff[1] : cfg_ff[`ADCDMX_CFG_DES];
  wire c_qsel   = pin_mode ? 1'b0 : cfg_ff[`ADCDMX_CFG_QSEL];
  wire c_ddr    = pin_mode ? pin_s2_ff[2] : cfg_ff[`ADCDMX_CFG_DDR];
  wire c_edge   = pin_mode ? pin_s2_ff[3] : cfg_ff[`ADCDMX_CFG_OED];
  wire c_demux  = pin_mode ? pin_s2_ff[0] :
                  (c_ddr ? cfg_ff[`ADCDMX_CFG_OED] :
                   cfg_ff[`ADCDMX_CFG_DEMUX]);

  // Latched modes change only while the output clock is in reset,
  // so the bus ordering can never shift within a stream.
  reg       m_des_ff;
  reg       m_qsel_ff;
  reg       m_ddr_ff;
  reg       m_edge_ff;
  reg       m_demux_ff;
  reg [2:0] sync_cnt_ff;
  reg       run_ff;
  reg       ph_ff;
  wire [2:0] sync_need = (m_demux_ff & m_ddr_ff & ~m_des_ff) ?
                         `ADCDMX_SYNC_CYC_DDR : `ADCDMX_SYNC_CYC;

  // The longer wait in demux DDR puts the first word on the same
  // clock phase that the other modes reach after three falls.
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      m_des_ff    <= 1'b0;
      m_qsel_ff   <= 1'b0;
      m_ddr_ff    <= 1'b0;
      m_edge_ff   <= 1'b0;
      m_demux_ff  <= 1'b0;
      sync_cnt_ff <= 3'h0;
      run_ff      <= 1'b0;
      ph_ff       <= 1'b0;
    end else if (rst_s2_ff) begin
      m_des_ff    <= c_des;
      m_qsel_ff   <= c_qsel;
      m_ddr_ff    <= c_ddr;
      m_edge_ff   <= c_edge;
      m_demux_ff  <= c_demux;
      sync_cnt_ff <= 3'h0;
      run_ff      <= 1'b0;
      ph_ff       <= 1'b0;
    end else if (ev_fall) begin
      if (!run_ff) begin
        if (sync_cnt_ff + 3'h1 == sync_need) begin
          run_ff <= 1'b1;
        end
        sync_cnt_ff <= sync_cnt_ff + 3'h1;
      end else begin
        ph_ff <= m_demux_ff ? ~ph_ff : 1'b0;
      end
    end
  end

  // Sample histories; index k holds the sample from k cycles back.
  // The histories run from reset on, so the first word after a
  // release of the output clock reset already carries real samples.
  reg [HW-1:0] fall_i_ff;
  reg [HW-1:0] fall_q_ff;
  reg [HW-1:0] rise_s_ff;
  wire [7:0] sel_in = m_qsel_ff ? din_q : din_i;
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fall_i_ff <= {HW{1'b0}};
      fall_q_ff <= {HW{1'b0}};
      rise_s_ff <= {HW{1'b0}};
    end else begin
      if (ev_fall) begin
        fall_i_ff <= push(fall_i_ff, m_des_ff ? sel_in : din_i);
        fall_q_ff <= push(fall_q_ff, din_q);
      end
      if (ev_rise) begin
        rise_s_ff <= push(rise_s_ff, sel_in);
      end
    end
  end

  // A word boundary sits on a fall; in demux only every other fall.
  wire upd = run_ff & ev_fall & (~m_demux_ff | ~ph_ff);
  wire mid = run_ff & (m_demux_ff ? (ev_fall & ph_ff) : ev_rise);
  // The histories shift on the very fall that reads them, so a fall
  // tap sits one index below its latency, while the newest rise is
  // already half a cycle old and the rise taps keep the full index.
  wire [3:0] lat_i_nd = (m_des_ff & m_qsel_ff) ? `ADCDMX_FALL_NEAR :
                        `ADCDMX_FALL_FAR;
  // Rise samples at index 13 are 13.5 cycles old at a fall.
  wire [7:0] q_near = m_des_ff ? pick(rise_s_ff, `ADCDMX_LAT_NEAR) :
                      pick(fall_q_ff, `ADCDMX_FALL_NEAR);
  wire [7:0] q_far  = m_des_ff ? pick(rise_s_ff, `ADCDMX_LAT_FAR) :
                      pick(fall_q_ff, `ADCDMX_FALL_FAR);

  // Codes pass unchanged; the cores already clamp to 00 or FF.
  // In non-demux the delayed buses keep their last byte; the enable
  // stays low, so the pads float and the stale byte is never seen.
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_i_bus_primary <= 8'h00;
      o_i_bus_delayed <= 8'h00;
      o_q_bus_primary <= 8'h00;
      o_q_bus_delayed <= 8'h00;
      o_delayed_oe    <= 1'b0;
    end else begin
      o_delayed_oe <= m_demux_ff & run_ff;
      if (upd) begin
        if (m_demux_ff) begin
          o_i_bus_primary <= pick(fall_i_ff, `ADCDMX_FALL_NEAR);
          o_i_bus_delayed <= pick(fall_i_ff, `ADCDMX_FALL_FAR);
          o_q_bus_primary <= q_near;
          o_q_bus_delayed <= q_far;
        end else begin
          o_i_bus_primary <= pick(fall_i_ff, lat_i_nd);
          o_q_bus_primary <= q_near;
        end
      end
    end
  end

  // Forwarded clock: SDR toggles at word and mid points, DDR at words.
  // In DDR the clock toggles with each word, so both edges launch data.
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_output_data_clock_p <= 1'b0;
      o_output_data_clock_n <= 1'b1;
    end else if (!run_ff) begin
      o_output_data_clock_p <= 1'b0;
      o_output_data_clock_n <= 1'b1;
    end else if (m_ddr_ff) begin
      if (upd) begin
        o_output_data_clock_p <= ~o_output_data_clock_p;
        o_output_data_clock_n <= o_output_data_clock_p;
      end
    end else if (upd) begin
      o_output_data_clock_p <= m_edge_ff;
      o_output_data_clock_n <= ~m_edge_ff;
    end else if (mid) begin
      o_output_data_clock_p <= ~m_edge_ff;
      o_output_data_clock_n <= m_edge_ff;
    end
  end

  // Background phase trim balances high and low time of the input
  // clock; it is coarse, limited by the system clock resolution.
  // The counters saturate so a stopped input clock cannot wrap them.
  reg  [7:0] hi_cnt_ff;
  reg  [7:0] lo_cnt_ff;
  reg  [7:0] hi_meas_ff;
  wire       trim_up = (hi_meas_ff > lo_cnt_ff) &&
                       (o_q_phase_trim != 6'h3F);
  wire       trim_dn = (hi_meas_ff < lo_cnt_ff) &&
                       (o_q_phase_trim != 6'h00);

  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_cnt_ff      <= 8'h00;
      lo_cnt_ff      <= 8'h00;
      hi_meas_ff     <= 8'h00;
      o_q_phase_trim <= `ADCDMX_TRIM_RESET;
    end else begin
      if (ev_rise) begin
        hi_cnt_ff <= 8'h00;
        lo_cnt_ff <= 8'h00;
        if (m_des_ff) begin
          if (trim_up) begin
            o_q_phase_trim <= o_q_phase_trim + 6'h01;
          end else if (trim_dn) begin
            o_q_phase_trim <= o_q_phase_trim - 6'h01;
          end
        end
      end else if (ev_fall) begin
        hi_meas_ff <= hi_cnt_ff;
      end else if (clk_s2_ff) begin
        if (hi_cnt_ff != 8'hFF) begin
          hi_cnt_ff <= hi_cnt_ff + 8'h01;
        end
      end else if (lo_cnt_ff != 8'hFF) begin
        lo_cnt_ff <= lo_cnt_ff + 8'h01;
      end
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY.
  // Reads are registered in the address phase, so hrdata stands
  // through the whole data phase without a wait state.
  reg       wr_pend_ff;
  reg [7:0] wr_addr_ff;
  wire      acc = i_hsel & i_hready & i_htrans[1];
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    case (i_haddr)
      `ADCDMX_ADDR_CFG:    rd_val = {26'h0, cfg_ff};
      `ADCDMX_ADDR_STATUS: rd_val = {26'h0, pin_mode, run_ff, m_demux_ff,
                                     m_ddr_ff, m_des_ff, m_edge_ff};
      `ADCDMX_ADDR_TRIM:   rd_val = {18'h0, hi_meas_ff, o_q_phase_trim};
      default:             rd_val = 32'h0000_0000;
    endcase
  end
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_pend_ff  <= 1'b0;
      wr_addr_ff  <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      o_dcc_en    <= 1'b1;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      wr_pend_ff  <= acc & i_hwrite;
      wr_addr_ff  <= i_haddr;
      if (acc & ~i_hwrite)
        o_hrdata <= rd_val;
      o_dcc_en <= cfg_ff[`ADCDMX_CFG_DCC];
    end
  end

  // The write is held one cycle, until hwdata stands in the data phase.
  always @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_ff <= `ADCDMX_CFG_RESET;
    end else if (wr_pend_ff && wr_addr_ff == `ADCDMX_ADDR_CFG) begin
      cfg_ff <= i_hwdata[5:0];
    end
  end

endmodule

/* include/adcdmx_defines.vh */
// Constants for the converter output clocking and demux block.
`ifndef ADCDMX_DEFINES_VH
`define ADCDMX_DEFINES_VH
`define ADCDMX_ADDR_CFG     8'h00
`define ADCDMX_ADDR_STATUS  8'h04
`define ADCDMX_ADDR_TRIM    8'h08
`define ADCDMX_CFG_OED      0
`define ADCDMX_CFG_DDR      1
`define ADCDMX_CFG_DES      2
`define ADCDMX_CFG_QSEL     3
`define ADCDMX_CFG_DEMUX    4
`define ADCDMX_CFG_DCC      5
`define ADCDMX_CFG_RESET    6'h20
`define ADCDMX_LAT_NEAR     4'hD
`define ADCDMX_LAT_FAR      4'hE
`define ADCDMX_FALL_NEAR    4'hC
`define ADCDMX_FALL_FAR     4'hD
`define ADCDMX_SYNC_CYC     3'h3
`define ADCDMX_SYNC_CYC_DDR 3'h4
`define ADCDMX_TRIM_RESET   6'h20
`define ADCDMX_HTRANS_NSEQ  2'h2
`endif

/* testbench/adcdmx_monitor.sv */
// Checker for the converter output clocking and demux block.
`timescale 1ns/1ps
module adcdmx_monitor (
  input wire        i_clk_sys,
  input wire        i_rst_b,
  input wire        i_output_clock_reset,
  input wire        i_ext_ctrl_b,
  input wire        i_oes_level,
  input wire        i_oes_float,
  input wire        i_demux_pin,
  input wire        i_hsel,
  input wire [7:0]  i_haddr,
  input wire [1:0]  i_htrans,
  input wire        i_hwrite,
  input wire        i_hready,
  input wire [31:0] o_hrdata,
  input wire        o_hreadyout,
  input wire        o_hresp,
  input wire [7:0]  o_i_bus_primary,
  input wire        o_delayed_oe,
  input wire        o_output_data_clock_p,
  input wire        o_output_data_clock_n,
  input wire        o_dcc_en,
  input wire [5:0]  o_q_phase_trim
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_clock_pair: assert property (
    o_output_data_clock_p != o_output_data_clock_n) else $error("clock pair");
  a_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus");
  a_clock_held: assert property (
    i_output_clock_reset [*5] |-> !o_output_data_clock_p && !o_delayed_oe)
    else $error("clock not held");
  a_sdr_edge: assert property (
    i_ext_ctrl_b && !i_oes_float && i_oes_level && !i_output_clock_reset &&
    $changed(o_i_bus_primary) && $changed(o_output_data_clock_p)
    |-> o_output_data_clock_p) else $error("wrong data edge");
  a_ddr_phase: assert property (
    i_ext_ctrl_b && i_oes_float && !i_output_clock_reset &&
    $changed(o_i_bus_primary) |-> $changed(o_output_data_clock_p))
    else $error("ddr phase");
  a_dcc_reset: assert property (
    !$past(i_rst_b) |-> o_dcc_en && o_q_phase_trim == 6'h20)
    else $error("reset values");
  a_unmapped_read: assert property (
    i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr == 8'h0C
    |=> o_hrdata == 32'h0) else $error("unmapped read");
  a_oe_nondemux: assert property (
    i_ext_ctrl_b && !i_oes_float && !i_demux_pin |-> !o_delayed_oe)
    else $error("delayed buses driven");
endmodule
bind adcdmx_top adcdmx_monitor i_mon (.*);

/* testbench/adcdmx_rx.sv */
// Receiver model that counts both clock edges and latches the forwarded bytes on the fall.
`timescale 1ns/1ps
module adcdmx_rx (
  input  wire         i_clk_p,
  input  wire  [7:0]  i_i_prim,
  input  wire  [7:0]  i_q_prim,
  output logic [15:0] o_caps = 16'h0,
  output logic [15:0] o_stream
);
  // Both edges are taken so one model serves SDR and DDR
  // The later q byte goes first when the stream is rebuilt
  always @(i_clk_p) begin
    o_caps <= o_caps + 16'h1;
  end
  // Bytes are taken on the fall, away from the launching rise
  always @(negedge i_clk_p) begin
    o_stream <= {i_q_prim, i_i_prim};
  end
endmodule

/* testbench/adcdmx_top_tb.sv */
// Self-checking bench for the converter output clocking and demux block.
`timescale 1ns/1ps
module adcdmx_top_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sclk = 1'b0;
  logic        ocr = 1'b1;
  logic        ext_b = 1'b1;
  logic        flt = 1'b0;
  logic        dmx = 1'b0;
  logic        des = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  di = 8'h00;
  logic [7:0]  dq = 8'h40;
  logic [7:0]  f = 8'h00;
  logic [31:0] rd;
  logic [15:0] c0;
  int          mismatches = 0;
  int          compares = 0;
  wire  [31:0] hrdata;
  wire         hready, hresp, oe, ckp, ckn, dcc;
  wire  [7:0]  ip, id, qp, qd;
  wire  [5:0]  trim;
  wire  [15:0] caps, strm;
  always #25 clk = ~clk;
  initial #13 forever #200 sclk = ~sclk;
  always @(negedge sclk) f <= f + 8'h01;
  // Data moves at the rise so it is settled at the sampling fall.
  always @(posedge sclk) begin
    di <= f;
    dq <= f + 8'h40;
  end
  adcdmx_top i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_sample_clk(sclk),
    .i_conv_i_data(di), .i_conv_q_data(dq), .i_output_clock_reset(ocr),
    .i_ext_ctrl_b(ext_b), .i_oes_level(1'b1), .i_oes_float(flt),
    .i_des_pin(des), .i_demux_pin(dmx), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .o_i_bus_primary(ip), .o_i_bus_delayed(id),
    .o_q_bus_primary(qp), .o_q_bus_delayed(qd), .o_delayed_oe(oe),
    .o_output_data_clock_p(ckp), .o_output_data_clock_n(ckn),
    .o_dcc_en(dcc), .o_q_phase_trim(trim));
  adcdmx_rx i_rx (.i_clk_p(ckp), .i_i_prim(ip), .i_q_prim(qp),
    .o_caps(caps), .o_stream(strm));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic start(input logic e, input logic fl, input logic m,
                       input logic d);
    @(posedge clk);
    ocr <= 1'b1;
    ext_b <= e;
    des <= d;
    flt <= fl;
    dmx <= m;
    repeat (10) @(posedge clk);
    ocr <= 1'b0;
    repeat (24) @(posedge sclk);
    #100;
  endtask
  task automatic stop_test;
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h20);
    chk(dcc, 1'b1);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    start(1'b1, 1'b0, 1'b0, 1'b0);
    c0 = caps;
    repeat (3) begin
      chk(ip, f - 8'h0F);
      chk(qp, f - 8'h0E + 8'h40);
      chk(oe, 1'b0);
      @(posedge sclk);
      #100;
    end
    chk(caps > c0, 1'b1);
    chk(8'(strm[15:8] - strm[7:0]), 8'h41);
    @(posedge clk);
    dmx <= 1'b1;
    repeat (6) @(posedge sclk);
    chk(oe, 1'b0);
    start(1'b1, 1'b0, 1'b0, 1'b1);
    repeat (3) begin
      chk(qp, f - 8'h0E);
      chk(ip, f - 8'h0F);
      @(posedge sclk);
      #100;
    end
    chk(trim, 6'h20);
    start(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (3) begin
      chk({24'h0, ip - 8'h01}, id);
      chk(ip == f - 8'h0E || ip == f - 8'h0F, 1'b1);
      chk(oe, 1'b1);
      @(posedge sclk);
      #100;
    end
    @(posedge clk);
    ocr <= 1'b1;
    ext_b <= 1'b0;
    ahb(1'b1, 8'h00, 32'h03);
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h03);
    chk(dcc, 1'b0);
    start(1'b0, 1'b0, 1'b0, 1'b0);
    chk(oe, 1'b1);
    stop_test;
  end
endmodule
